// *** rtl/shr_ctrl_regs.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the stop/halt recovery block
// Assumes: 8-bit register port, sys_clk at 125 MHz
// Notes:   Definitions only
`ifndef SHR_CTRL_REGS_SVH
`define SHR_CTRL_REGS_SVH

// Register offsets
`define SHR_ADDR_RECOV     8'h0B
`define SHR_ADDR_RECOV2    8'h0D
`define SHR_ADDR_STATUS    8'h0E
`define SHR_ADDR_MASK      8'h0F

// Fields of the primary recovery-control register
`define SHR_F_PRESCALE     0
`define SHR_F_NODIV2       1
`define SHR_F_SRC_LO       2
`define SHR_F_DELAY_EN     5
`define SHR_F_WAKE_HIGH    6
`define SHR_F_WARM         7
`define SHR_RECOV_RST      7'h20

// Status and mask bit positions
`define SHR_ST_HALT        0
`define SHR_ST_STOP        1
`define SHR_ST_WAKE        2
`define SHR_ST_WDOG        3
`define SHR_ST_PGOOD       4
`define SHR_ST_NONOP       5
`define SHR_ST_W           6

// Opcodes and restart vector
`define SHR_OP_NOP         8'hFF
`define SHR_OP_STOP        8'h6F
`define SHR_OP_HALT        8'h7F
`define SHR_RESTART_VEC    12'h00C

// Reset delay: time in ns, rounded up to cycles of the 8 ns clock
`define SHR_CLK_NS         8
`define SHR_TPOR_NS        1000
`define SHR_TPOR_CYC       ((`SHR_TPOR_NS + `SHR_CLK_NS - 1) / `SHR_CLK_NS)
`define SHR_DLY_W          16
`define SHR_SYNC_W         15

`endif

// *** rtl/shr_pkg.sv ***
// Purpose: Types of the stop/halt recovery block
// Assumes: shr_ctrl_regs.svh supplies the widths
// Notes:   State of the controller is one packed struct
`include "shr_ctrl_regs.svh"

package shr_pkg;

  typedef enum logic [1:0]
  {
    SHR_RUN   = 2'b00,
    SHR_HALT  = 2'b01,
    SHR_STOP  = 2'b10,
    SHR_DELAY = 2'b11
  } shr_state_t;

  typedef struct packed
  {
    shr_state_t             state;
    logic [`SHR_SYNC_W-1:0] sync1;
    logic [`SHR_SYNC_W-1:0] sync2;
    logic                   pg_prev;
    logic                   prev_nop;
    logic [6:0]             recov;
    logic [1:0]             recov2;
    logic                   warm;
    logic [`SHR_ST_W-1:0]   status;
    logic [`SHR_ST_W-1:0]   mask;
    logic [`SHR_DLY_W-1:0]  dly_cnt;
    logic                   div_ph;
    logic [3:0]             pre_cnt;
    logic                   cpu_clk_en;
    logic                   sys_tick;
    logic                   timer_tick;
    logic                   osc_run;
    logic                   cpu_reset;
    logic                   restart;
    logic                   halt_resume;
    logic                   irq;
    logic [7:0]             rdata;
  } shr_state_s_t;

endpackage : shr_pkg

// *** rtl/shr_ctrl.sv ***
// Purpose: HALT/STOP entry, wake-up detection, reset-delay one-shot and clock dividers
// Assumes: sys_clk is the oscillator; pins and power_good arrive asynchronously
// Notes:   Register port answers reads one cycle later and never stalls
`timescale 1ns/1ns
`include "shr_ctrl_regs.svh"

// Function
// - Reset delay one-shot fires on power-good, watchdog, or delayed STOP recovery.
// - HALT gates CPU clock; oscillator, timers and three external interrupts stay alive.
// - Enabled interrupt ends HALT and resumes; power or watchdog reset restarts at 000CH.
// - STOP halts clocks; only watchdog, power-on or recovery event end it, restarting.
// - Opcode 6F is STOP, 7F is HALT; a NOP must precede either.
// - Primary register at 0BH: bits 0-6 write-only, bit 7 read-only status.
// - Bit 0 enables divide-by-16; cleared by STOP recovery, watchdog or power-on.
// - Bit 1 low divides oscillator by two; high passes it directly.
// - Three-bit source selects reset only, port 3 bit, port2_bit7, or NOR groups.
// - Pins configured as analog inputs cannot wake the part from STOP.
// - Port 2 pins configured as outputs are sampled at their driven level.
// - Bit 5, reset 1, delays after STOP recovery; power-on and watchdog always delay.
// - Bit 6 sets wake level through XOR, for both recovery registers.
// - Bit 7 reads 0 after cold reset, 1 after STOP wake or watchdog-from-STOP.
// - Secondary two-bit source selects reset only or AND of port 2 groups.
module shr_ctrl #(
  parameter int unsigned POR_DELAY_CYC = `SHR_TPOR_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic [7:0]  cpu_opcode,
  input  wire logic        cpu_opcode_valid,
  input  wire logic        irq_enable,
  input  wire logic        timer_irq,
  input  wire logic        watchdog_unit_timeout,
  input  wire logic        power_good,
  input  wire logic [2:0]  external_irq,
  input  wire logic [3:1]  port3_pin,
  input  wire logic [7:0]  port2_pin,
  input  wire logic [7:0]  port2_is_output,
  input  wire logic [7:0]  port2_out_level,
  input  wire logic [7:0]  port2_analog,
  input  wire logic [3:1]  port3_analog,
  output logic             cpu_clk_en,
  output logic             sys_tick,
  output logic             timer_tick,
  output logic             osc_run,
  output logic             cpu_reset,
  output logic             restart,
  output logic      [11:0] restart_vector,
  output logic             halt_resume,
  output logic             irq
);

  localparam logic [`SHR_DLY_W-1:0] DLY_LAST = `SHR_DLY_W'(POR_DELAY_CYC - 1);

  shr_pkg::shr_state_s_t st_r;
  shr_pkg::shr_state_s_t st_nxt;

  logic [7:0] p2_eff;
  logic [7:0] p2_ok;
  logic [3:1] p3_val;
  logic [2:0] irq_s;
  logic       pg_s;
  logic       src_val;
  logic       src_ok;
  logic       wake_req;

  // Synchronised pin views; only the second stage is ever read
  assign irq_s  = st_r.sync2[13:11];
  assign pg_s   = st_r.sync2[14];
  assign p3_val = st_r.sync2[10:8];

  // Per pin: outputs read back their driven level, analog pins are unusable
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_p2
      assign p2_eff[gi] = port2_is_output[gi] ? port2_out_level[gi] : st_r.sync2[gi];
      assign p2_ok[gi]  = ~port2_analog[gi];
    end
  endgenerate

  // Wake source mux; the program keeps only one of the two fields non-zero
  always_comb
  begin
    src_val = 1'b0;
    src_ok  = 1'b0;
    case (st_r.recov[4:2])
      3'b010:
      begin
        src_val = p3_val[1];
        src_ok  = ~port3_analog[1];
      end
      3'b011:
      begin
        src_val = p3_val[2];
        src_ok  = ~port3_analog[2];
      end
      3'b100:
      begin
        src_val = p3_val[3];
        src_ok  = ~port3_analog[3];
      end
      3'b101:
      begin
        src_val = p2_eff[7];
        src_ok  = p2_ok[7];
      end
      3'b110:
      begin
        src_val = ~|p2_eff[3:0];
        src_ok  = &p2_ok[3:0];
      end
      3'b111:
      begin
        src_val = ~|p2_eff;
        src_ok  = &p2_ok;
      end
      default:
      begin
        src_val = 1'b0;
        src_ok  = 1'b0;
      end
    endcase
    // Secondary field only acts while the primary source field is 000 (not at reset-only code 001)
    if (st_r.recov[4:2] == 3'b000)
    begin
      case (st_r.recov2)
        2'b01:
        begin
          src_val = &p2_eff[3:0];
          src_ok  = &p2_ok[3:0];
        end
        2'b10:
        begin
          src_val = &p2_eff;
          src_ok  = &p2_ok;
        end
        default:
        begin
          src_val = 1'b0;
          src_ok  = 1'b0;
        end
      endcase
    end
  end

  // Level select via XOR: wake when the source equals the chosen level
  assign wake_req = src_ok & ~(src_val ^ st_r.recov[`SHR_F_WAKE_HIGH]);

  // Next state of everything
  always_comb
  begin
    logic                  base_tick;
    logic                  div_tick;
    logic                  halt_wake;
    logic                  run_clk;
    logic                  tmr_clk;
    logic [`SHR_ST_W-1:0]  ev;
    st_nxt    = st_r;
    base_tick = 1'b0;
    div_tick  = 1'b0;
    halt_wake = 1'b0;
    run_clk   = 1'b0;
    tmr_clk   = 1'b0;
    ev        = '0;

    // Two-stage synchronisers
    st_nxt.sync1   = {power_good, external_irq, port3_pin, port2_pin};
    st_nxt.sync2   = st_r.sync1;
    st_nxt.pg_prev = pg_s;

    // One-cycle outputs default low
    st_nxt.restart     = 1'b0;
    st_nxt.halt_resume = 1'b0;

    // NOP tracking for sleep entry
    if (cpu_opcode_valid)
    begin
      st_nxt.prev_nop = (cpu_opcode == `SHR_OP_NOP);
    end

    case (st_r.state)
      shr_pkg::SHR_RUN:
      begin
        if (watchdog_unit_timeout)
        begin
          st_nxt.state                   = shr_pkg::SHR_DELAY;
          st_nxt.dly_cnt                 = '0;
          st_nxt.warm                    = 1'b0;
          st_nxt.recov[`SHR_F_PRESCALE]  = 1'b0;
          ev[`SHR_ST_WDOG]               = 1'b1;
        end
        else if (cpu_opcode_valid && (cpu_opcode == `SHR_OP_HALT || cpu_opcode == `SHR_OP_STOP))
        begin
          if (!st_r.prev_nop)
          begin
            ev[`SHR_ST_NONOP] = 1'b1; // Pipeline not flushed: refuse to sleep
          end
          else if (cpu_opcode == `SHR_OP_HALT)
          begin
            st_nxt.state       = shr_pkg::SHR_HALT;
            ev[`SHR_ST_HALT]   = 1'b1;
          end
          else
          begin
            st_nxt.state       = shr_pkg::SHR_STOP;
            st_nxt.warm        = 1'b1; // Set on STOP entry
            ev[`SHR_ST_STOP]   = 1'b1;
          end
        end
      end
      shr_pkg::SHR_HALT:
      begin
        halt_wake = irq_enable & ((|irq_s) | timer_irq);
        if (watchdog_unit_timeout)
        begin
          st_nxt.state                   = shr_pkg::SHR_DELAY;
          st_nxt.dly_cnt                 = '0;
          st_nxt.warm                    = 1'b0;
          st_nxt.recov[`SHR_F_PRESCALE]  = 1'b0;
          ev[`SHR_ST_WDOG]               = 1'b1;
        end
        else if (halt_wake)
        begin
          st_nxt.state       = shr_pkg::SHR_RUN;
          st_nxt.halt_resume = 1'b1;
        end
      end
      shr_pkg::SHR_STOP:
      begin
        if (watchdog_unit_timeout)
        begin
          st_nxt.state                   = shr_pkg::SHR_DELAY;
          st_nxt.dly_cnt                 = '0;
          st_nxt.warm                    = 1'b1;
          st_nxt.recov[`SHR_F_PRESCALE]  = 1'b0;
          ev[`SHR_ST_WDOG]               = 1'b1;
        end
        else if (wake_req)
        begin
          st_nxt.warm                    = 1'b1;
          st_nxt.recov[`SHR_F_PRESCALE]  = 1'b0;
          ev[`SHR_ST_WAKE]               = 1'b1;
          if (st_r.recov[`SHR_F_DELAY_EN])
          begin
            st_nxt.state   = shr_pkg::SHR_DELAY;
            st_nxt.dly_cnt = '0;
          end
          else
          begin
            st_nxt.state   = shr_pkg::SHR_RUN;
            st_nxt.restart = 1'b1;
          end
        end
      end
      shr_pkg::SHR_DELAY:
      begin
        // A watchdog time-out during the delay starts the one-shot over
        if (watchdog_unit_timeout)
        begin
          st_nxt.dly_cnt                 = '0;
          st_nxt.recov[`SHR_F_PRESCALE]  = 1'b0;
          ev[`SHR_ST_WDOG]               = 1'b1;
        end
        // The one-shot only counts while power is good
        else if (pg_s)
        begin
          if (st_r.dly_cnt >= DLY_LAST)
          begin
            st_nxt.state   = shr_pkg::SHR_RUN;
            st_nxt.restart = 1'b1;
          end
          else
          begin
            st_nxt.dly_cnt = st_r.dly_cnt + 1'b1;
          end
        end
      end
      default:
      begin
        st_nxt.state = shr_pkg::SHR_DELAY;
      end
    endcase

    // Power fail acts as power-on: restore defaults and hold the one-shot
    if (!pg_s)
    begin
      st_nxt.state   = shr_pkg::SHR_DELAY;
      st_nxt.dly_cnt = '0;
      st_nxt.recov   = `SHR_RECOV_RST;
      st_nxt.recov2  = '0;
      st_nxt.warm    = 1'b0;
    end
    else if (!st_r.pg_prev)
    begin
      ev[`SHR_ST_PGOOD] = 1'b1;
    end

    // Register writes; bit 7 is hardware-owned
    if (reg_wr && reg_addr == `SHR_ADDR_RECOV)
    begin
      st_nxt.recov = reg_wdata[6:0];
    end
    if (reg_wr && reg_addr == `SHR_ADDR_RECOV2)
    begin
      st_nxt.recov2 = reg_wdata[1:0];
    end
    if (reg_wr && reg_addr == `SHR_ADDR_MASK)
    begin
      st_nxt.mask = reg_wdata[`SHR_ST_W-1:0];
    end

    // Read data, one cycle later; write-only bits read as zero
    st_nxt.rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        `SHR_ADDR_RECOV:  st_nxt.rdata = {st_r.warm, 7'h00};
        `SHR_ADDR_STATUS: st_nxt.rdata = {2'h0, st_r.status};
        `SHR_ADDR_MASK:   st_nxt.rdata = {2'h0, st_r.mask};
        default:          st_nxt.rdata = 8'h00;
      endcase
    end

    // Sticky status: a read clears, a same-cycle event still lands
    if (reg_rd && reg_addr == `SHR_ADDR_STATUS)
    begin
      st_nxt.status = ev;
    end
    else
    begin
      st_nxt.status = st_r.status | ev;
    end
    st_nxt.irq = |(st_nxt.status & st_nxt.mask);

    // Clock dividers: oscillator/2 or /1, then optional /16
    run_clk = (st_nxt.state == shr_pkg::SHR_RUN); // Coming state, so no tick outlives its enable
    tmr_clk = run_clk | (st_nxt.state == shr_pkg::SHR_HALT);
    if (st_r.state != shr_pkg::SHR_STOP)
    begin
      st_nxt.div_ph = ~st_r.div_ph;
    end
    base_tick = st_r.recov[`SHR_F_NODIV2] ? 1'b1 : st_r.div_ph;
    if (base_tick && st_r.state != shr_pkg::SHR_STOP)
    begin
      st_nxt.pre_cnt = st_r.pre_cnt + 1'b1;
    end
    div_tick = base_tick & (~st_r.recov[`SHR_F_PRESCALE] | (&st_r.pre_cnt));

    st_nxt.sys_tick   = div_tick & run_clk;
    st_nxt.timer_tick = div_tick & tmr_clk;
    st_nxt.cpu_clk_en = (st_nxt.state == shr_pkg::SHR_RUN);
    st_nxt.osc_run    = (st_nxt.state != shr_pkg::SHR_STOP);
    st_nxt.cpu_reset  = (st_nxt.state == shr_pkg::SHR_DELAY);
  end

  // Single state register
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r <= '{state: shr_pkg::SHR_DELAY, recov: `SHR_RECOV_RST, cpu_reset: 1'b1, osc_run: 1'b1,
                default: '0};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register; restart_vector is the fixed SHR_RESTART_VEC
  assign reg_rdata      = st_r.rdata;
  assign cpu_clk_en     = st_r.cpu_clk_en;
  assign sys_tick       = st_r.sys_tick;
  assign timer_tick     = st_r.timer_tick;
  assign osc_run        = st_r.osc_run;
  assign cpu_reset      = st_r.cpu_reset;
  assign restart        = st_r.restart;
  assign restart_vector = `SHR_RESTART_VEC;
  assign halt_resume    = st_r.halt_resume;
  assign irq            = st_r.irq;

endmodule // shr_ctrl

// *** test/shr_ctrl_asserts.sv ***
// Purpose: Port checks of the stop/halt recovery controller
// Assumes: one clock, nrst async active low
// Notes:   Bound into shr_ctrl
`timescale 1ns/1ns
module shr_ctrl_asserts #(
  parameter int unsigned POR_DELAY_CYC = 125
) (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [7:0]  cpu_opcode,
  input wire logic        cpu_opcode_valid,
  input wire logic        irq_enable,
  input wire logic        watchdog_unit_timeout,
  input wire logic        cpu_clk_en,
  input wire logic        sys_tick,
  input wire logic        timer_tick,
  input wire logic        osc_run,
  input wire logic        cpu_reset,
  input wire logic        restart,
  input wire logic [11:0] restart_vector,
  input wire logic        halt_resume
);
  logic [15:0] dly_cnt_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // Length of the current reset delay, so a short one-shot is caught
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      dly_cnt_r <= 16'h0000;
    else if (!cpu_reset)
      dly_cnt_r <= 16'h0000;
    else
      dly_cnt_r <= dly_cnt_r + 16'h0001;
  end

  // Sleep opcode right after a NOP, taken while running
  sequence slp(logic [7:0] op);
    cpu_opcode_valid && cpu_opcode == op && $past(cpu_opcode_valid) && $past(cpu_opcode) == 8'hFF
      && cpu_clk_en && !cpu_reset;
  endsequence

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  a_vec_fixed: assert property (restart |-> restart_vector == 12'h00C)
    else $error("restart vector wrong");
  a_halt_gate: assert property (slp(8'h7F) |=> !cpu_clk_en && osc_run)
    else $error("halt entry wrong");
  a_stop_gate: assert property (slp(8'h6F) |=> !cpu_clk_en && !osc_run)
    else $error("stop entry wrong");
  a_nop_first: assert property (cpu_opcode_valid && (cpu_opcode == 8'h7F || cpu_opcode == 8'h6F)
    && !($past(cpu_opcode_valid) && $past(cpu_opcode) == 8'hFF) && cpu_clk_en && !cpu_reset
    && !watchdog_unit_timeout |=> cpu_clk_en)
    else $error("sleep taken without NOP");
  a_tick_gated: assert property (!cpu_clk_en |-> !sys_tick)
    else $error("cpu tick while gated");
  a_stop_quiet: assert property (!osc_run |-> !timer_tick && !cpu_clk_en)
    else $error("clock alive in stop");
  a_wdog_delay: assert property (watchdog_unit_timeout |=> cpu_reset)
    else $error("watchdog gave no delay");
  a_restart_one: assert property (restart |=> !restart)
    else $error("restart longer than a cycle");
  a_delay_end: assert property ($fell(cpu_reset) |-> restart && dly_cnt_r >= POR_DELAY_CYC)
    else $error("reset delay short or no restart");
  a_resume_cause: assert property (halt_resume |-> cpu_clk_en && $past(irq_enable))
    else $error("halt left without interrupt");

  c_restart: cover property (restart);
  c_resume: cover property (halt_resume);
  c_stop: cover property (!osc_run);
endmodule // shr_ctrl_asserts

bind shr_ctrl shr_ctrl_asserts #(.POR_DELAY_CYC(POR_DELAY_CYC)) u_shr_ctrl_asserts (
  .sys_clk, .nrst, .reg_rd, .reg_rdata, .cpu_opcode, .cpu_opcode_valid, .irq_enable,
  .watchdog_unit_timeout, .cpu_clk_en, .sys_tick, .timer_tick, .osc_run, .cpu_reset,
  .restart, .restart_vector, .halt_resume
);

// *** test/shr_far_model.sv ***
// Purpose: Far side: supply monitor, watchdog and wake pins
// Assumes: commanded by the bench through its tasks
// Notes:   Port 3 parks high so a low-level wake waits for a command
`timescale 1ns/1ns
module shr_far_model (
  input wire logic  sys_clk,
  output logic      power_good,
  output logic      watchdog_unit_timeout,
  output logic [2:0] external_irq,
  output logic [3:1] port3_pin,
  output logic [7:0] port2_pin
);
  // Supply good from the start, pins idle
  initial
  begin
    power_good = 1'b1;
    watchdog_unit_timeout = 1'b0;
    external_irq = 3'h0;
    port3_pin = 3'h7;
    port2_pin = 8'h00;
  end

  // One-cycle time-out, changed just after an edge
  task automatic wdog_pulse();
  begin
    @(posedge sys_clk);
    watchdog_unit_timeout <= 1'b1;
    @(posedge sys_clk);
    watchdog_unit_timeout <= 1'b0;
  end
  endtask

  // New pin levels, held until the next command
  task automatic set_pins(input logic [3:1] p3, input logic [7:0] p2);
  begin
    @(posedge sys_clk);
    port3_pin <= p3;
    port2_pin <= p2;
  end
  endtask
endmodule // shr_far_model

// *** test/tb_top.sv ***
// Purpose: Self-checking bench of the stop/halt recovery controller
// Assumes: 125 MHz clock, reset delay shortened to 4 cycles
// Notes:   Pins and watchdog come from the far-side model
`timescale 1ns/1ns
module tb_top;
  logic        sys_clk = 1'b0;
  logic        nrst;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [7:0]  cpu_opcode;
  logic        cpu_opcode_valid;
  logic        irq_enable;
  logic        timer_irq;
  logic        watchdog_unit_timeout;
  logic        power_good;
  logic [2:0]  external_irq;
  logic [3:1]  port3_pin;
  logic [7:0]  port2_pin;
  logic [3:1]  port3_analog;
  logic [7:0]  port2_is_output;
  logic [7:0]  port2_out_level;
  logic [7:0]  port2_analog;
  logic        sys_tick;
  logic        cpu_clk_en;
  logic        timer_tick;
  logic        osc_run;
  logic        cpu_reset;
  logic        restart;
  logic [11:0] restart_vector;
  logic        halt_resume;
  logic        irq;
  logic        rst_seen;
  int          num_errors = 0;
  int          n_compared = 0;

  // 8 ns period
  always #4 sys_clk = ~sys_clk;

  shr_far_model u_far (.sys_clk, .power_good, .watchdog_unit_timeout, .external_irq, .port3_pin, .port2_pin);

  // Pin configuration (analog, output) is driven by the bench, same clock
  shr_ctrl #(.POR_DELAY_CYC(4)) u_shr_ctrl (
    .sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_opcode, .cpu_opcode_valid,
    .irq_enable, .timer_irq, .watchdog_unit_timeout, .power_good, .external_irq, .port3_pin, .port2_pin,
    .port2_is_output, .port2_out_level, .port2_analog, .port3_analog, .cpu_clk_en,
    .sys_tick, .timer_tick, .osc_run, .cpu_reset, .restart, .restart_vector, .halt_resume, .irq
  );

  // Count sys_tick pulses over n cycles
  task automatic ticks(input int n, input logic [11:0] exp, input string what);
    logic [11:0] cnt;
  begin
    cnt = 12'h000;
    repeat (n)
    begin
      @(posedge sys_clk);
      #1;
      cnt = cnt + {11'h000, sys_tick};
    end
    chk(what, exp, cnt);
  end
  endtask

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
  begin
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
  begin
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  end
  endtask

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
  begin
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, {4'h0, exp}, {4'h0, reg_rdata});
  end
  endtask

  // Two consecutive opcodes
  task automatic opc(input logic [7:0] a, input logic [7:0] b);
  begin
    @(posedge sys_clk);
    cpu_opcode_valid <= 1'b1;
    cpu_opcode <= a;
    @(posedge sys_clk);
    cpu_opcode <= b;
    @(posedge sys_clk);
    cpu_opcode_valid <= 1'b0;
    cpu_opcode <= 8'h00;
    #1;
  end
  endtask

  // Bounded wait for restart or a timer tick, noting any reset delay seen
  task automatic wait_flag(input logic tick, input string what);
  begin
    #1;
    rst_seen = 1'b0;
    for (int i = 0; i < 60; i++)
    begin
      if ((tick ? timer_tick : restart) === 1'b1)
        break;
      rst_seen = rst_seen | cpu_reset;
      @(posedge sys_clk);
      #1;
    end
    chk(what, 12'h001, {11'h000, tick ? timer_tick : restart});
  end
  endtask

  task automatic conclude();
  begin
    $display("compared %0d mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask

  // Whole run is under a thousand cycles; twenty thousand means a hang
  initial
  begin
    #160000;
    num_errors++;
    conclude();
  end

  // Test sequence
  initial
  begin
    nrst = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cpu_opcode = 8'h00;
    cpu_opcode_valid = 1'b0;
    irq_enable = 1'b0;
    timer_irq = 1'b0;
    port3_analog = 3'h0;
    port2_is_output = 8'h00;
    port2_out_level = 8'h00;
    port2_analog = 8'h00;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    wait_flag(1'b0, "power_restart");
    chk("delay", 12'h001, {11'h000, rst_seen});
    chk("vector", 12'h00C, restart_vector);
    rd(8'h0B, 8'h00, "cold");
    rd(8'h0D, 8'h00, "recov2");
    rd(8'h3A, 8'h00, "unmapped");
    rd(8'h0E, 8'h10, "status_pg");
    ticks(8, 12'h004, "sys_tick_div2");
    wr(8'h0B, 8'h23);
    ticks(32, 12'h002, "sys_tick_div16");
    wr(8'h0B, 8'h22);
    ticks(8, 12'h008, "sys_tick_div1");
    $display("reset test done");
    // Halt with its event unmasked, left by an enabled interrupt
    wr(8'h0F, 8'h01);
    opc(8'hFF, 8'h7F);
    chk("cpu_clk_en", 12'h000, {11'h000, cpu_clk_en});
    chk("osc_run", 12'h001, {11'h000, osc_run});
    wait_flag(1'b1, "timer_tick");
    chk("irq", 12'h001, {11'h000, irq});
    @(posedge sys_clk);
    irq_enable <= 1'b1;
    timer_irq <= 1'b1;
    @(posedge sys_clk);
    timer_irq <= 1'b0;
    irq_enable <= 1'b0;
    #1;
    chk("halt_resume", 12'h001, {11'h000, halt_resume});
    chk("cpu_clk_en", 12'h001, {11'h000, cpu_clk_en});
    rd(8'h0E, 8'h01, "status_halt");
    @(posedge sys_clk);
    #1;
    chk("irq", 12'h000, {11'h000, irq});
    $display("halt test done");
    // Sleep opcode without NOP is refused
    opc(8'h00, 8'h6F);
    chk("osc_run", 12'h001, {11'h000, osc_run});
    rd(8'h0E, 8'h20, "status_nonop");
    $display("no nop test done");
    // Stop, wake on port3_bit1 low, blocked while analog, delayed restart
    wr(8'h0B, 8'h29);
    opc(8'hFF, 8'h6F);
    chk("osc_run", 12'h000, {11'h000, osc_run});
    port3_analog <= 3'h1;
    u_far.set_pins(3'h6, 8'h00);
    repeat (8) @(posedge sys_clk);
    #1;
    chk("osc_run", 12'h000, {11'h000, osc_run});
    @(posedge sys_clk);
    port3_analog <= 3'h0;
    wait_flag(1'b0, "stop_restart");
    chk("delay", 12'h001, {11'h000, rst_seen});
    u_far.set_pins(3'h7, 8'h00);
    rd(8'h0B, 8'h80, "warm");
    rd(8'h0E, 8'h06, "status_stop");
    ticks(8, 12'h004, "prescale_clear");
    $display("stop low test done");
    // Stop, wake on port2_bit7 high, no delay
    wr(8'h0B, 8'h54);
    opc(8'hFF, 8'h6F);
    chk("osc_run", 12'h000, {11'h000, osc_run});
    u_far.set_pins(3'h7, 8'h80);
    wait_flag(1'b0, "stop_restart");
    chk("delay", 12'h000, {11'h000, rst_seen});
    u_far.set_pins(3'h7, 8'h00);
    $display("stop high test done");
    // Stop, wake on AND of port2 bits 0-3 high; bit 0 is an output read at its driven level
    wr(8'h0B, 8'h40);
    wr(8'h0D, 8'h01);
    opc(8'hFF, 8'h6F);
    chk("osc_run", 12'h000, {11'h000, osc_run});
    port2_analog <= 8'h01;
    port2_is_output <= 8'h01;
    port2_out_level <= 8'h01;
    u_far.set_pins(3'h7, 8'h0E);
    repeat (8) @(posedge sys_clk);
    #1;
    chk("osc_run", 12'h000, {11'h000, osc_run});
    @(posedge sys_clk);
    port2_analog <= 8'h00;
    wait_flag(1'b0, "and_restart");
    chk("delay", 12'h000, {11'h000, rst_seen});
    port2_is_output <= 8'h00;
    port2_out_level <= 8'h00;
    u_far.set_pins(3'h7, 8'h00);
    $display("stop and test done");
    // Watchdog while running: delayed restart, cold start
    u_far.wdog_pulse();
    wait_flag(1'b0, "wdog_restart");
    chk("delay", 12'h001, {11'h000, rst_seen});
    rd(8'h0B, 8'h00, "cold");
    rd(8'h0E, 8'h0E, "status_wdog");
    $display("watchdog test done");
    conclude();
  end
endmodule // tb_top
